/* File: byte_op_defines.vh */
// register map, field positions and opcode encodings of the byte-op decoder
// assumes a 32-bit APB bus with byte addresses on paddr
`ifndef BYTE_OP_DEFINES_VH
`define BYTE_OP_DEFINES_VH

`define REG_INSTR      8'h00
`define REG_WORK       8'h04
`define REG_FLAGS      8'h08
`define REG_BANK       8'h0C
`define REG_CTRL       8'h10
`define REG_PROD       8'h14
`define REG_INFO       8'h18
`define REG_TARGET     8'h1C
`define REG_FADDR      8'h20
`define REG_FDATA      8'h24

`define FLAG_C         0
`define FLAG_DC        1
`define FLAG_Z         2
`define FLAG_OV        3
`define FLAG_N         4
`define FLAGS_RESET    5'h00
`define DEST_BIT       9
`define ACCESS_BIT     8
`define ACCESS_BANK    4'h0
`define PORT_ADDR_DEF  12'hF10
`define TIMER_ADDR_DEF 12'hF20

`define PFX_SECOND     4'hF
`define OP_FILE_TO_FILE_MOVE_OP       4'hC
`define OP_GOTO        8'hEF
`define OP_LFSR        8'hEE
`define OP_CALL        7'h76
`define OP_BRA         5'h1A
`define OP_RCALL       5'h1B
`define OP_BCOND       5'h1C

`define OP_DECF        6'h01
`define OP_OR_WORK_FILE_OP       6'h04
`define OP_AND_WORK_FILE_OP       6'h05
`define OP_XOR_WORK_FILE_OP       6'h06
`define OP_COMPLEMENT_FILE_OP        6'h07
`define OP_ADD_WORK_CARRY_OP      6'h08
`define OP_ADDWF       6'h09
`define OP_INCF        6'h0A
`define OP_DECREMENT_SKIP_ZERO_OP      6'h0B
`define OP_ROTATE_RIGHT_CARRY_OP        6'h0C
`define OP_ROTATE_LEFT_CARRY_OP        6'h0D
`define OP_SWAPF       6'h0E
`define OP_INCREMENT_SKIP_ZERO_OP      6'h0F
`define OP_ROTATE_RIGHT_PLAIN_OP       6'h10
`define OP_ROTATE_LEFT_PLAIN_OP       6'h11
`define OP_INCREMENT_SKIP_NONZERO_OP      6'h12
`define OP_DECREMENT_SKIP_NONZERO_OP      6'h13
`define OP_MOVF        6'h14
`define OP_SUB_FILE_FROM_WORK_BORROW_OP      6'h15
`define OP_SUB_WORK_FROM_FILE_BORROW_OP      6'h16
`define OP_SUBWF       6'h17

`define OP_MULTIPLY_WORK_FILE_OP       7'h01
`define OP_COMPARE_SKIP_LESS_OP      7'h30
`define OP_COMPARE_SKIP_EQUAL_OP      7'h31
`define OP_COMPARE_SKIP_GREATER_OP      7'h32
`define OP_TSTFSZ      7'h33
`define OP_SETF        7'h34
`define OP_CLRF        7'h35
`define OP_NEGF        7'h36
`define OP_MOVWF       7'h37

`define OP_BTG         4'h7
`define OP_BSF         4'h8
`define OP_BCF         4'h9
`define OP_BTFSS       4'hA
`define OP_BTFSC       4'hB

`define OP_ADDLW       8'h0F
`define OP_ANDLW       8'h0B
`define OP_IORLW       8'h09

`endif

/* File: file_ram.v */
// data memory holding the file registers, one write port and a registered read
// assumes a single clock; contents are not reset
`timescale 1ns/100ps
`default_nettype none
module file_ram #(
  parameter ADDR_W = 12,
  parameter DATA_W = 8
) (
  input  wire              clk,
  input  wire              rst_n,
  input  wire              we,
  input  wire [ADDR_W-1:0] addr,
  input  wire [DATA_W-1:0] wdata,
  output reg  [DATA_W-1:0] rdata
);
  reg [DATA_W-1:0] mem [0:(1<<ADDR_W)-1];

  always @(posedge clk) begin
    if (we) begin
      mem[addr] <= wdata;
    end
  end

  // read data lags the address by one edge
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata <= {DATA_W{1'b0}};
    end else begin
      rdata <= mem[addr];
    end
  end
endmodule
`default_nettype wire

/* File: byte_op_instruction_decoder.v */
// decoder and executor for 16-bit instruction words, fed one word per APB write
// assumes an APB master on pclk and asynchronous port pins on port_pins
// Contract
// [RULE1] d=0 sends result to working register
// [RULE2] d=1 writes result back to file
// [RULE3] a=0 forces access bank, else bank register
// [RULE4] file move: two words, 12-bit addresses
// [RULE5] bit ops: bit position, access, file
// [RULE6] literal ops use low byte operand
// [RULE7] jump/call 20-bit target, call fast bit
// [RULE8] branch offsets 11-bit or 8-bit signed
// [RULE9] add with carry sets five flags
// [RULE10] file from work borrow sets five flags
// [RULE11] work from file borrow sets five flags
// [RULE12] logical ops set zero and negative only
// [RULE13] carry rotates set carry, zero, negative
// [RULE14] plain rotates set zero, negative only
// [RULE15] compare skips change no flags
// [RULE16] decrement skips change no flags
// [RULE17] increment skips change no flags
// [RULE18] multiply one cycle, no flags
// [RULE19] port operand read from pin levels
// [RULE20] timer write clears assigned prescaler
// [RULE21] taken branch or skip costs two
// [RULE22] lone second word is no-operation
// [RULE23] product goes to high/low byte pair
// [RULE24] skipped two-word instruction costs three
//
// Decided for this implementation: the register addresses and the APB interface to the registers.
`include "byte_op_defines.vh"
`timescale 1ns/100ps
`default_nettype none
module byte_op_instruction_decoder #(
  parameter ADDR_W     = 12,
  parameter PORT_ADDR  = `PORT_ADDR_DEF,
  parameter TIMER_ADDR = `TIMER_ADDR_DEF
) (
  input  wire        pclk,
  input  wire        presetn,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [7:0]  paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output wire        pready,
  output wire        pslverr,
  input  wire [7:0]  port_pins,
  output reg         prescaler_clear
);
  localparam ST_IDLE  = 2'b00;
  localparam ST_READ  = 2'b01;
  localparam ST_EXEC  = 2'b10;
  localparam ST_FWAIT = 2'b11;
  localparam PK_NONE  = 2'b00;
  localparam PK_FILE_TO_FILE_MOVE_OP = 2'b01;
  localparam PK_JUMP  = 2'b10;
  localparam PK_LFSR  = 2'b11;

  reg [1:0]        state;
  reg [7:0]        working_register;
  reg [4:0]        flags;
  reg [3:0]        bank_select_reg;
  reg              presc_assigned;
  reg [7:0]        product_high_byte;
  reg [7:0]        product_low_byte;
  reg [7:0]        result_byte;
  reg [1:0]        last_cycles;
  reg              skip_next;
  reg              second_pending;
  reg [1:0]        pend_kind;
  reg [7:0]        held_byte;
  reg [7:0]        held_low;
  reg              fast_bit;
  reg [19:0]       branch_target;
  reg              branch_taken;
  reg [15:0]       cur_word;
  reg [ADDR_W-1:0] op_addr;
  reg [ADDR_W-1:0] file_addr;
  reg              done;
  reg [7:0]        pin_s1;
  reg [7:0]        pin_s2;
  reg [7:0]        pin_s3;
  reg [7:0]        pin_val;

  wire [15:0]       w = pwdata[15:0];
  wire [7:0]        mem_rdata;
  wire              access = psel & penable;
  wire              is_instr = pwrite & (paddr == `REG_INSTR);
  wire              is_fdata = (paddr == `REG_FDATA);
  wire              start = access & ~done & (state == ST_IDLE) & (is_instr | is_fdata);
  wire [ADDR_W-1:0] bank_addr;
  wire [7:0]        fdata;
  // condition codes: 00 zero, 01 carry, 10 overflow, 11 negative; bit 8 inverts
  wire              cond_hit = ((w[10:9] == 2'b00) ? flags[`FLAG_Z] :
                                (w[10:9] == 2'b01) ? flags[`FLAG_C] :
                                (w[10:9] == 2'b10) ? flags[`FLAG_OV] : flags[`FLAG_N]) ^ w[8];
  reg               mem_we;
  reg [ADDR_W-1:0]  mem_addr;
  reg [7:0]         mem_wdata;
  reg               mapped;
  reg [31:0]        next_prdata;

  function [10:0] add8;
    input [7:0] a;
    input [7:0] b;
    input       cin;
    reg   [8:0] s;
    reg   [4:0] lo;
    begin
      s     = {1'b0, a} + {1'b0, b} + {8'h00, cin};
      lo    = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, cin};
      add8  = {(a[7] == b[7]) && (s[7] != a[7]), lo[4], s[8], s[7:0]};
    end
  endfunction

  function [4:0] arith_flags;
    input [10:0] r;
    begin
      arith_flags            = 5'h00;
      arith_flags[`FLAG_C]   = r[8];
      arith_flags[`FLAG_DC]  = r[9];
      arith_flags[`FLAG_OV]  = r[10];
      arith_flags[`FLAG_Z]   = (r[7:0] == 8'h00);
      arith_flags[`FLAG_N]   = r[7];
    end
  endfunction

  function [4:0] zn_flags;
    input [4:0] f;
    input [7:0] v;
    begin
      zn_flags          = f;
      zn_flags[`FLAG_Z] = (v == 8'h00);
      zn_flags[`FLAG_N] = v[7];
    end
  endfunction

  function is_two_word;
    input [15:0] iw;
    begin
      is_two_word = (iw[15:12] == `OP_FILE_TO_FILE_MOVE_OP) || (iw[15:8] == `OP_GOTO) ||
                    (iw[15:9] == `OP_CALL) || (iw[15:8] == `OP_LFSR);
    end
  endfunction

  function is_file_op;
    input [15:0] iw;
    begin
      is_file_op = (iw[15:12] >= 4'h1 && iw[15:12] <= `OP_BTFSC) ||
                   (iw[15:10] == `OP_DECF) || (iw[15:9] == `OP_MULTIPLY_WORK_FILE_OP) ||
                   (iw[15:12] == 4'h0 && iw[11:10] != 2'b00 && iw[15:10] != 6'h02 && iw[15:10] != 6'h03);
    end
  endfunction

  // [RULE3] access bank or bank register
  assign bank_addr = w[`ACCESS_BIT] ? {bank_select_reg, w[7:0]} : {`ACCESS_BANK, w[7:0]};
  // [RULE19] port operand from pins
  assign fdata     = (op_addr == PORT_ADDR) ? pin_val : mem_rdata;
  assign pready    = (is_instr | is_fdata) ? done : 1'b1;
  assign pslverr   = access & pready & ~mapped;

  // a pin bit changes only once the second and third stages agree
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_s1  <= 8'h00;
      pin_s2  <= 8'h00;
      pin_s3  <= 8'h00;
      pin_val <= 8'h00;
    end else begin
      pin_s1  <= port_pins;
      pin_s2  <= pin_s1;
      pin_s3  <= pin_s2;
      pin_val <= (pin_val & (pin_s2 ^ pin_s3)) | (pin_s2 & ~(pin_s2 ^ pin_s3));
    end
  end

  reg [15:0] iw;
  reg [7:0]  opnd;
  reg [10:0] r;
  reg [7:0]  ex_val;
  reg [4:0]  ex_flags;
  reg        ex_write;
  reg        ex_file;
  reg        ex_skip;
  reg        ex_mul;
  reg [7:0]  bmask;

  // in idle only the literal group uses this result; file groups use it in exec
  always @* begin
    iw       = (state == ST_IDLE) ? w : cur_word;
    opnd     = (state == ST_IDLE) ? w[7:0] : fdata;
    r        = 11'h000;
    ex_val   = opnd;
    ex_flags = flags;
    ex_write = 1'b0;
    // [RULE1] [RULE2] destination select
    ex_file  = iw[`DEST_BIT];
    ex_skip  = 1'b0;
    ex_mul   = 1'b0;
    // [RULE5] bit position field
    bmask    = 8'h01 << iw[11:9];
    case (iw[15:10])
      // [RULE9] add with carry
      `OP_ADD_WORK_CARRY_OP: begin r = add8(working_register, opnd, flags[`FLAG_C]); ex_write = 1'b1; end
      `OP_ADDWF:  begin r = add8(working_register, opnd, 1'b0); ex_write = 1'b1; end
      `OP_INCF:   begin r = add8(opnd, 8'h00, 1'b1); ex_write = 1'b1; end
      `OP_DECF:   begin r = add8(opnd, 8'hFF, 1'b0); ex_write = 1'b1; end
      `OP_SUBWF:  begin r = add8(opnd, ~working_register, 1'b1); ex_write = 1'b1; end
      // [RULE10] work minus file with borrow
      `OP_SUB_FILE_FROM_WORK_BORROW_OP: begin r = add8(working_register, ~opnd, flags[`FLAG_C]); ex_write = 1'b1; end
      // [RULE11] file minus work with borrow
      `OP_SUB_WORK_FROM_FILE_BORROW_OP: begin r = add8(opnd, ~working_register, flags[`FLAG_C]); ex_write = 1'b1; end
      default:    r = 11'h000;
    endcase
    case (iw[15:10])
      `OP_ADD_WORK_CARRY_OP, `OP_ADDWF, `OP_INCF, `OP_DECF, `OP_SUBWF, `OP_SUB_FILE_FROM_WORK_BORROW_OP, `OP_SUB_WORK_FROM_FILE_BORROW_OP: begin
        ex_val   = r[7:0];
        ex_flags = arith_flags(r);
      end
      // [RULE12] logical ops touch zero and negative
      `OP_AND_WORK_FILE_OP: begin ex_val = working_register & opnd; ex_flags = zn_flags(flags, ex_val); ex_write = 1'b1; end
      `OP_OR_WORK_FILE_OP: begin ex_val = working_register | opnd; ex_flags = zn_flags(flags, ex_val); ex_write = 1'b1; end
      `OP_XOR_WORK_FILE_OP: begin ex_val = working_register ^ opnd; ex_flags = zn_flags(flags, ex_val); ex_write = 1'b1; end
      `OP_COMPLEMENT_FILE_OP:  begin ex_val = ~opnd; ex_flags = zn_flags(flags, ex_val); ex_write = 1'b1; end
      `OP_MOVF:  begin ex_flags = zn_flags(flags, opnd); ex_write = 1'b1; end
      // [RULE13] rotate through carry
      `OP_ROTATE_LEFT_CARRY_OP: begin
        ex_val = {opnd[6:0], flags[`FLAG_C]};
        ex_flags = zn_flags(flags, ex_val);
        ex_flags[`FLAG_C] = opnd[7];
        ex_write = 1'b1;
      end
      `OP_ROTATE_RIGHT_CARRY_OP: begin
        ex_val = {flags[`FLAG_C], opnd[7:1]};
        ex_flags = zn_flags(flags, ex_val);
        ex_flags[`FLAG_C] = opnd[0];
        ex_write = 1'b1;
      end
      // [RULE14] plain rotates
      `OP_ROTATE_LEFT_PLAIN_OP: begin ex_val = {opnd[6:0], opnd[7]}; ex_flags = zn_flags(flags, ex_val); ex_write = 1'b1; end
      `OP_ROTATE_RIGHT_PLAIN_OP: begin ex_val = {opnd[0], opnd[7:1]}; ex_flags = zn_flags(flags, ex_val); ex_write = 1'b1; end
      `OP_SWAPF: begin ex_val = {opnd[3:0], opnd[7:4]}; ex_write = 1'b1; end
      // [RULE16] decrement and skip, flags kept
      `OP_DECREMENT_SKIP_ZERO_OP: begin ex_val = opnd - 8'h01; ex_skip = (ex_val == 8'h00); ex_write = 1'b1; end
      `OP_DECREMENT_SKIP_NONZERO_OP: begin ex_val = opnd - 8'h01; ex_skip = (ex_val != 8'h00); ex_write = 1'b1; end
      // [RULE17] increment and skip, flags kept
      `OP_INCREMENT_SKIP_ZERO_OP: begin ex_val = opnd + 8'h01; ex_skip = (ex_val == 8'h00); ex_write = 1'b1; end
      `OP_INCREMENT_SKIP_NONZERO_OP: begin ex_val = opnd + 8'h01; ex_skip = (ex_val != 8'h00); ex_write = 1'b1; end
      default: begin
        case (iw[15:9])
          // [RULE18] multiply leaves flags
          `OP_MULTIPLY_WORK_FILE_OP:  ex_mul = 1'b1;
          // [RULE15] compare skips, no flags
          `OP_COMPARE_SKIP_EQUAL_OP: ex_skip = (opnd == working_register);
          `OP_COMPARE_SKIP_GREATER_OP: ex_skip = (opnd > working_register);
          `OP_COMPARE_SKIP_LESS_OP: ex_skip = (opnd < working_register);
          `OP_TSTFSZ: ex_skip = (opnd == 8'h00);
          `OP_SETF:   begin ex_val = 8'hFF; ex_write = 1'b1; ex_file = 1'b1; end
          `OP_CLRF: begin
            ex_val = 8'h00;
            ex_flags[`FLAG_Z] = 1'b1;
            ex_write = 1'b1;
            ex_file = 1'b1;
          end
          `OP_NEGF: begin
            r = add8(~opnd, 8'h00, 1'b1);
            ex_val = r[7:0];
            ex_flags = arith_flags(r);
            ex_write = 1'b1;
            ex_file = 1'b1;
          end
          `OP_MOVWF:  begin ex_val = working_register; ex_write = 1'b1; ex_file = 1'b1; end
          default: begin
            case (iw[15:12])
              `OP_BSF:   begin ex_val = opnd | bmask; ex_write = 1'b1; ex_file = 1'b1; end
              `OP_BCF:   begin ex_val = opnd & ~bmask; ex_write = 1'b1; ex_file = 1'b1; end
              `OP_BTG:   begin ex_val = opnd ^ bmask; ex_write = 1'b1; ex_file = 1'b1; end
              `OP_BTFSS: ex_skip = ((opnd & bmask) != 8'h00);
              `OP_BTFSC: ex_skip = ((opnd & bmask) == 8'h00);
              default: begin
                // [RULE6] literal in low byte
                ex_file = 1'b0;
                case (iw[15:8])
                  `OP_ADDLW: begin
                    r = add8(working_register, opnd, 1'b0);
                    ex_val = r[7:0];
                    ex_flags = arith_flags(r);
                    ex_write = 1'b1;
                  end
                  `OP_ANDLW: begin ex_val = working_register & opnd; ex_flags = zn_flags(flags, ex_val); ex_write = 1'b1; end
                  `OP_IORLW: begin ex_val = working_register | opnd; ex_flags = zn_flags(flags, ex_val); ex_write = 1'b1; end
                  default:   ex_write = 1'b0;
                endcase
              end
            endcase
          end
        endcase
      end
    endcase
  end

  // memory port: the engine owns it; software reaches it only through the data window
  always @* begin
    mem_we    = 1'b0;
    mem_addr  = op_addr;
    mem_wdata = ex_val;
    if (state == ST_IDLE && start) begin
      if (is_fdata) begin
        mem_addr  = file_addr;
        mem_we    = pwrite;
        mem_wdata = pwdata[7:0];
      end else if (!skip_next && second_pending && pend_kind == PK_FILE_TO_FILE_MOVE_OP) begin
        // [RULE4] second word names destination
        mem_addr  = w[ADDR_W-1:0];
        mem_we    = 1'b1;
        mem_wdata = held_byte;
      end
    end else if (state == ST_EXEC) begin
      mem_we = ex_write & ex_file & (pend_kind != PK_FILE_TO_FILE_MOVE_OP);
    end
  end

  always @* begin
    mapped      = 1'b1;
    next_prdata = 32'h0000_0000;
    case (paddr)
      `REG_INSTR:  next_prdata = {16'h0000, cur_word};
      `REG_WORK:   next_prdata = {24'h000000, working_register};
      `REG_FLAGS:  next_prdata = {27'h0000000, flags};
      `REG_BANK:   next_prdata = {28'h0000000, bank_select_reg};
      `REG_CTRL:   next_prdata = {31'h00000000, presc_assigned};
      `REG_PROD:   next_prdata = {16'h0000, product_high_byte, product_low_byte};
      `REG_INFO:   next_prdata = {19'h00000, result_byte, branch_taken, second_pending, skip_next, last_cycles};
      `REG_TARGET: next_prdata = {11'h000, fast_bit, branch_target};
      `REG_FADDR:  next_prdata = {{(32-ADDR_W){1'b0}}, file_addr};
      `REG_FDATA:  next_prdata = 32'h0000_0000;
      default:     mapped = 1'b0;
    endcase
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata          <= 32'h0000_0000;
      prescaler_clear <= 1'b0;
    end else begin
      prdata          <= (state == ST_FWAIT) ? {24'h000000, mem_rdata} : next_prdata;
      // [RULE20] timer write clears prescaler
      prescaler_clear <= mem_we & (mem_addr == TIMER_ADDR) & presc_assigned;
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state             <= ST_IDLE;
      working_register  <= 8'h00;
      flags             <= `FLAGS_RESET;
      bank_select_reg   <= 4'h0;
      presc_assigned    <= 1'b0;
      product_high_byte <= 8'h00;
      product_low_byte  <= 8'h00;
      result_byte       <= 8'h00;
      last_cycles       <= 2'd0;
      skip_next         <= 1'b0;
      second_pending    <= 1'b0;
      pend_kind         <= PK_NONE;
      held_byte         <= 8'h00;
      held_low          <= 8'h00;
      fast_bit          <= 1'b0;
      branch_target     <= 20'h00000;
      branch_taken      <= 1'b0;
      cur_word          <= 16'h0000;
      op_addr           <= {ADDR_W{1'b0}};
      file_addr         <= {ADDR_W{1'b0}};
      done              <= 1'b0;
    end else begin
      done <= 1'b0;
      if (access & pwrite & ~is_instr & ~is_fdata) begin
        case (paddr)
          `REG_WORK:  working_register <= pwdata[7:0];
          `REG_FLAGS: flags <= pwdata[4:0];
          `REG_BANK:  bank_select_reg <= pwdata[3:0];
          `REG_CTRL:  presc_assigned <= pwdata[0];
          `REG_FADDR: file_addr <= pwdata[ADDR_W-1:0];
          default:    done <= 1'b0;
        endcase
      end
      case (state)
        ST_IDLE: begin
          if (start && is_fdata) begin
            if (pwrite) begin
              done <= 1'b1;
            end else begin
              state <= ST_FWAIT;
            end
          end else if (start) begin
            cur_word    <= w;
            last_cycles <= 2'd1;
            if (skip_next) begin
              // [RULE24] discarded word; a two-word first word keeps the skip alive
              skip_next <= is_two_word(w);
              done      <= 1'b1;
            end else if (second_pending) begin
              second_pending <= 1'b0;
              done           <= 1'b1;
              if (pend_kind == PK_JUMP) begin
                // [RULE7] upper twelve target bits
                branch_target <= {w[11:0], held_low};
                branch_taken  <= 1'b1;
              end
            end else if (w[15:12] == `PFX_SECOND) begin
              // [RULE22] stray second word
              done <= 1'b1;
            end else if (w[15:12] == `OP_FILE_TO_FILE_MOVE_OP) begin
              // [RULE4] source address from first word
              op_addr   <= w[ADDR_W-1:0];
              pend_kind <= PK_FILE_TO_FILE_MOVE_OP;
              state     <= ST_READ;
            end else if (w[15:8] == `OP_GOTO || w[15:9] == `OP_CALL || w[15:8] == `OP_LFSR) begin
              // [RULE7] low target bits, fast bit
              second_pending <= 1'b1;
              pend_kind      <= (w[15:8] == `OP_LFSR) ? PK_LFSR : PK_JUMP;
              held_low       <= w[7:0];
              fast_bit       <= (w[15:9] == `OP_CALL) & w[8];
              branch_taken   <= 1'b0;
              done           <= 1'b1;
            end else if (w[15:11] == `OP_BRA || w[15:11] == `OP_RCALL) begin
              // [RULE8] [RULE21] eleven-bit offset, two cycles
              branch_target <= {{9{w[10]}}, w[10:0]};
              branch_taken  <= 1'b1;
              last_cycles   <= 2'd2;
              done          <= 1'b1;
            end else if (w[15:11] == `OP_BCOND) begin
              // [RULE8] [RULE21] eight-bit offset, taken costs two
              branch_target <= {{12{w[7]}}, w[7:0]};
              branch_taken <= cond_hit;
              last_cycles  <= cond_hit ? 2'd2 : 2'd1;
              done        <= 1'b1;
            end else if (is_file_op(w)) begin
              op_addr   <= bank_addr;
              pend_kind <= PK_NONE;
              state     <= ST_READ;
            end else begin
              if (ex_write) begin
                working_register <= ex_val;
                flags            <= ex_flags;
                result_byte      <= ex_val;
              end
              done <= 1'b1;
            end
          end
        end
        ST_READ: begin
          state <= ST_EXEC;
        end
        ST_EXEC: begin
          state <= ST_IDLE;
          done  <= 1'b1;
          if (pend_kind == PK_FILE_TO_FILE_MOVE_OP) begin
            held_byte      <= fdata;
            second_pending <= 1'b1;
          end else begin
            // [RULE1] result to working register
            if (ex_write && !ex_file) begin
              working_register <= ex_val;
            end
            flags       <= ex_flags;
            result_byte <= ex_val;
            // [RULE21] skip condition arms discard
            skip_next   <= ex_skip;
            if (ex_mul) begin
              // [RULE23] product into byte pair
              {product_high_byte, product_low_byte} <= working_register * fdata;
            end
          end
        end
        default: begin
          state <= ST_IDLE;
          done  <= 1'b1;
        end
      endcase
    end
  end

  file_ram #(
    .ADDR_W (ADDR_W),
    .DATA_W (8)
  ) u_file_ram (
    .clk   (pclk),
    .rst_n (presetn),
    .we    (mem_we),
    .addr  (mem_addr),
    .wdata (mem_wdata),
    .rdata (mem_rdata)
  );
endmodule
`default_nettype wire

/* File: byte_op_sva.sv */
// concurrent checks on the APB timing and prescaler pulse of the byte-op decoder
// assumes it is bound to the decoder top module and sees only its ports
`include "byte_op_defines.vh"
`timescale 1ns/100ps
`default_nettype none
module byte_op_sva (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        prescaler_clear
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_instr_waits: assert property (
    psel && !penable && pwrite && paddr == `REG_INSTR |=> !pready) else $error("instr write did not wait");
  a_instr_bound: assert property (
    psel && penable && pwrite && paddr == `REG_INSTR |-> ##[0:3] pready) else $error("instr write too slow");
  a_fdata_read: assert property (
    psel && !penable && !pwrite && paddr == `REG_FDATA |=> !pready ##1 !pready ##1 pready)
    else $error("fdata read wait count wrong");
  a_prod_ready: assert property (
    psel && !penable && paddr == `REG_PROD |=> pready && !pslverr) else $error("product read stalled");
  a_unmapped_err: assert property (
    psel && penable && pready && paddr > `REG_FDATA |-> pslverr && prdata == 32'h0) else $error("unmapped not refused");
  a_mapped_ok: assert property (
    psel && penable && paddr <= `REG_FDATA && paddr[1:0] == 2'h0 |-> !pslverr) else $error("mapped access errored");
  a_clear_pulse: assert property (
    prescaler_clear |=> !prescaler_clear) else $error("prescaler clear longer than one cycle");
  a_clear_cause: assert property (
    $rose(prescaler_clear) |-> $past(psel) && $past(pwrite)) else $error("prescaler clear without a write");
endmodule
bind byte_op_instruction_decoder byte_op_sva byte_op_sva_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .prescaler_clear(prescaler_clear));
`default_nettype wire

/* File: pin_source.sv */
// pin-side source that drives the decoder's port pin levels
// assumes the bench sets the wanted level; pins move only on a clock edge
`timescale 1ns/100ps
`default_nettype none
module pin_source (
  input  wire logic       pclk,
  input  wire logic [7:0] level,
  output var  logic [7:0] port_pins
);
  always @(posedge pclk) port_pins <= level;
endmodule
`default_nettype wire

/* File: byte_op_instruction_decoder_tb.sv */
// self-checking bench: feeds instruction words and registers over APB
// assumes pin_source and the bound checker are compiled before it
`include "byte_op_defines.vh"
`timescale 1ns/100ps
`default_nettype none
module byte_op_instruction_decoder_tb;
  logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic        pready, pslverr, prescaler_clear;
  logic [7:0]  paddr = 0, port_pins;
  logic [31:0] pwdata = 0, prdata, q;
  int          failures = 0, n_tests = 0, cycles = 0, pulses = 0;
  always #5 pclk = ~pclk;
  pin_source pin_source_inst (.pclk(pclk), .level(8'hA5), .port_pins(port_pins));
  byte_op_instruction_decoder byte_op_instruction_decoder_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .port_pins(port_pins), .prescaler_clear(prescaler_clear));
  task close_out;
    if (failures == 0 && n_tests > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // a hang in a pready wait ends here as a failure
  always @(posedge pclk) begin
    cycles++;
    if (prescaler_clear === 1'b1) pulses++;
    if (cycles == 5000) begin
      failures++;
      close_out;
    end
  end
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    do @(posedge pclk); while (pready !== 1'b1);
    q = prdata;
    psel <= 0;
    penable <= 0;
  endtask
  task chk(input string n, input logic [31:0] s, input logic [31:0] e);
    n_tests++;
    if (s !== e) begin
      failures++;
      $display("wrong value %s expected %h seen %h", n, e, s);
    end
  endtask
  task rc(input logic [7:0] a, input logic [31:0] e, input string n);
    apb(1'b0, a, 32'h0);
    chk(n, q, e);
  endtask
  task ex(input logic [15:0] w);
    apb(1'b1, `REG_INSTR, {16'h0, w});
  endtask
  task mem(input logic [11:0] a, input logic [7:0] d);
    apb(1'b1, `REG_FADDR, {20'h0, a});
    apb(1'b1, `REG_FDATA, {24'h0, d});
  endtask
  initial begin
    repeat (5) @(posedge pclk);
    presetn <= 1;
    apb(1'b1, `REG_WORK, 32'h10);
    apb(1'b1, `REG_FLAGS, 32'h1);
    apb(1'b1, `REG_BANK, 32'h2);
    mem(12'h205, 8'h22);
    ex(16'h2305);
    rc(`REG_FDATA, 32'h33, "banked file");
    rc(`REG_FLAGS, 32'h0, "flags add");
    mem(12'h005, 8'h80);
    ex(16'h2005);
    rc(`REG_WORK, 32'h90, "access bank work");
    rc(`REG_FLAGS, 32'h10, "flags negative");
    ex(16'h0305);
    rc(`REG_PROD, 32'h1CB0, "product");
    rc(`REG_FLAGS, 32'h10, "flags multiply");
    mem(12'h005, 8'h01);
    ex(16'h2E05);
    ex(16'hC123);
    ex(16'hF456);
    ex(16'h0F05);
    rc(`REG_WORK, 32'h95, "work after skip");
    rc(`REG_FDATA, 32'h0, "decremented file");
    ex(16'hF0FF);
    ex(16'h0F05);
    rc(`REG_WORK, 32'h9A, "work after lone word");
    ex(16'hD400);
    rc(`REG_TARGET, 32'hFFC00, "branch offset");
    ex(16'hEF12);
    ex(16'hF345);
    rc(`REG_TARGET, 32'h34512, "jump target");
    apb(1'b1, `REG_BANK, 32'hF);
    mem(12'hF10, 8'h00);
    ex(16'h5110);
    rc(`REG_WORK, 32'hA5, "port pins");
    apb(1'b1, `REG_CTRL, 32'h1);
    ex(16'h2B20);
    ex(16'h2920);
    chk("prescaler clears", pulses, 32'h1);
    apb(1'b1, `REG_FLAGS, 32'h4);
    ex(16'hE0F0);
    rc(`REG_TARGET, 32'hFFFF0, "short offset");
    apb(1'b0, `REG_INFO, 32'h0);
    chk("taken branch cycles", q & 32'h13, 32'h12);
    apb(1'b0, 8'h30, 32'h0);
    close_out;
  end
endmodule
`default_nettype wire
